/* rtl/rsr_defs.svh */
// rsr_defs.svh: offsets, field positions, reset values and counts of the
// resampler loop, sync and output control registers.
// assumes: included by the package and by every design file that needs it.
`ifndef RSR_DEFS_SVH
`define RSR_DEFS_SVH

// register addresses on the 4-bit control address bus
`define RSR_ADDR_GAIN_FIRST 4'h6
`define RSR_ADDR_GAIN_SECOND 4'h7
`define RSR_ADDR_SYNC_SELECT 4'h8
`define RSR_ADDR_COUNTER_CTRL 4'h9
`define RSR_ADDR_OUTPUT_OPT 4'hA

// reset values
`define RSR_RST_GAIN_FIRST 8'h00
`define RSR_RST_GAIN_SECOND 8'h00
`define RSR_RST_SYNC_SELECT 8'h00
`define RSR_RST_COUNTER_CTRL 8'h00
`define RSR_RST_OUTPUT_OPT 8'h00

// field positions
`define RSR_GAIN_LSB 0
`define RSR_GAIN_MSB 4
`define RSR_ERR_INV_BIT 5
`define RSR_GAIN_LOAD_LSB 6
`define RSR_RATIO_LOAD_LSB 0
`define RSR_RATE_INT_LSB 2
`define RSR_PHASE_INT_LSB 4
`define RSR_SYNC_OUT_LSB 6
`define RSR_PERIOD_LSB 0
`define RSR_PERIOD_MSB 3
`define RSR_CNT_SYNC_LSB 4
`define RSR_TEST_PAT_BIT 6
`define RSR_FIFO_RST_LSB 0
`define RSR_BYPASS_BIT 2
`define RSR_VALID_ADV_BIT 4
`define RSR_VALID_INV_BIT 5

// sync counter: shortest period exponent and step per selector bit
`define RSR_CNT_W 20
`define RSR_CNT_EXP_BASE 4
`define RSR_CNT_EXP_STEP 4
`define RSR_TEST_PAT_W 12

`endif

/* rtl/rsr_loop_sync_regs.sv */
// rsr_loop_sync_regs: rate-lock-loop gain, sync source, sync counter and
// output option registers of the resampler, with the logic they steer.
// assumes: control bus and pins synchronous to clk; one-shot control bit
// and resampler datapath live outside this block.
// Function
// - gain register low five bits hold first loop shift; top bits unused.
// - nonzero shift scales loop error by two to minus shift.
// - zero shift forces that loop path error to zero.
// - with polarity clear, high external error raises ratio.
// - polarity bit set inverts external error input.
// - second gain register bits 6-7 pick when new shifts reach the loop.
// - sync codes: 0 never, 1 sync input, 2 terminal count, 3 always.
// - active-low sync pin inverted into active-high internal sync.
// - sync select bits 0-1 pick ratio load sync.
// - sync select bits 2-3 pick rate integrator init sync.
// - sync select bits 4-5 pick phase integrator init sync.
// - sync select bits 6-7 drive inverted sync pin; code 0 one-shot.
// - counter bits 0-3 set period 2^4 to 2^20.
// - counter bits 4-5 pick counter resync: never, input, one-shot, always.
// - counter bit 6 substitutes 12 counter LSBs for sample data.
// - output bits 0-1 pick FIFO half-full reset sync.
// - bypass bit routes data and valid around FIFO; clocks equal.
// - valid strobe in cycle before data change; advance bit one earlier.
// - valid strobe active high; invert bit makes it active low.
// - host accesses eight-bit registers by select, strobes, address, data.
// - one-shot strobe once per rising control bit write.
`timescale 1ns/10ps
`include "rsr_defs.svh"

module rsr_loop_sync_regs #(
	parameter int ERR_W = 16,
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control bus
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] cdata_in,
	output logic [7:0] cdata_out,
	output logic cdata_oe,
	// sync pins and one-shot control bit
	input wire logic sync_in_n,
	output logic sync_out_n,
	input wire logic one_shot_bit,
	// rate lock loop
	input wire logic signed [ERR_W-1:0] loop_error,
	output logic signed [ERR_W-1:0] path_first_err,
	output logic signed [ERR_W-1:0] path_second_err,
	input wire logic external_error_input,
	output logic error_raise_ratio,
	// integrator and load syncs
	output logic ratio_load_sync,
	output logic rate_integrator_sync,
	output logic phase_integrator_sync,
	output logic fifo_reset_sync,
	// sample data into the resampler
	input wire logic [DATA_W-1:0] sample_in,
	output logic [DATA_W-1:0] core_data_in,
	// output path
	input wire logic [DATA_W-1:0] core_data,
	input wire logic core_change_ahead,
	input wire logic [DATA_W-1:0] fifo_data,
	input wire logic fifo_change_ahead,
	output logic [DATA_W-1:0] data_out,
	output logic output_valid_strobe,
	output logic fifo_bypassed
);
	import rsr_pkg::*;

	initial begin
		if (ERR_W < 2 || DATA_W < `RSR_TEST_PAT_W) begin
			$error("rsr_loop_sync_regs: ERR_W or DATA_W out of range");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta_r;
	logic rst_s_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_s_n <= rst_meta_r;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_s_n);

	////////////////////////////////////////////////////////////////////////
	// register file
	logic [7:0] gain_first_r;
	logic [7:0] gain_second_r;
	logic [7:0] sync_select_r;
	logic [7:0] counter_ctrl_r;
	logic [7:0] output_opt_r;
	logic wr_en;
	logic rd_en;
	logic hit;

	assign hit = (addr >= `RSR_ADDR_GAIN_FIRST) && (addr <= `RSR_ADDR_OUTPUT_OPT);
	assign wr_en = !cs_n && !wr_n && rd_n && hit;
	assign rd_en = !cs_n && !rd_n && wr_n && hit;
	assign cdata_oe = rd_en;

	// full byte stored, unused bits read back
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			gain_first_r <= `RSR_RST_GAIN_FIRST;
			gain_second_r <= `RSR_RST_GAIN_SECOND;
			sync_select_r <= `RSR_RST_SYNC_SELECT;
			counter_ctrl_r <= `RSR_RST_COUNTER_CTRL;
			output_opt_r <= `RSR_RST_OUTPUT_OPT;
		end else if (wr_en) begin
			case (addr)
				`RSR_ADDR_GAIN_FIRST: gain_first_r <= cdata_in;
				`RSR_ADDR_GAIN_SECOND: gain_second_r <= cdata_in;
				`RSR_ADDR_SYNC_SELECT: sync_select_r <= cdata_in;
				`RSR_ADDR_COUNTER_CTRL: counter_ctrl_r <= cdata_in;
				`RSR_ADDR_OUTPUT_OPT: output_opt_r <= cdata_in;
				default: gain_first_r <= gain_first_r;
			endcase
		end
	end

	// read data registered; valid one cycle after the read strobe starts
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			cdata_out <= 8'h00;
		end else begin
			case (addr)
				`RSR_ADDR_GAIN_FIRST: cdata_out <= gain_first_r;
				`RSR_ADDR_GAIN_SECOND: cdata_out <= gain_second_r;
				`RSR_ADDR_SYNC_SELECT: cdata_out <= sync_select_r;
				`RSR_ADDR_COUNTER_CTRL: cdata_out <= counter_ctrl_r;
				`RSR_ADDR_OUTPUT_OPT: cdata_out <= output_opt_r;
				default: cdata_out <= 8'h00;
			endcase
		end
	end

	a_reg_readback: assert property (wr_en ##1 (rd_en && $stable(addr)) |=> cdata_out == $past(cdata_in, 2))
		else $error("register read does not return written byte");

	////////////////////////////////////////////////////////////////////////
	// sync sources
	logic sync_in_act;
	logic one_shot_prev_r;
	logic one_shot_pulse_r;
	logic cnt_terminal;
	logic cnt_sync;
	logic [`RSR_CNT_W-1:0] cnt_value;

	assign sync_in_act = !sync_in_n;

	// one pulse per rising control bit
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			one_shot_prev_r <= 1'b0;
			one_shot_pulse_r <= 1'b0;
		end else begin
			one_shot_prev_r <= one_shot_bit;
			one_shot_pulse_r <= one_shot_bit && !one_shot_prev_r;
		end
	end

	a_one_shot_once: assert property (one_shot_pulse_r |=> !one_shot_pulse_r)
		else $error("one-shot strobe lasted more than one cycle");

	assign cnt_sync = rsr_sync_pick(counter_ctrl_r[`RSR_CNT_SYNC_LSB +: 2], 1'b0, sync_in_act, one_shot_pulse_r);

	rsr_sync_counter #(
		.CNT_W(`RSR_CNT_W)
	) u_counter (
		.clk(clk),
		.rst_n(rst_s_n),
		.period_code(counter_ctrl_r[`RSR_PERIOD_MSB:`RSR_PERIOD_LSB]),
		.sync_evt(cnt_sync),
		.count(cnt_value),
		.terminal(cnt_terminal)
	);

	a_period_short: assert property (counter_ctrl_r[3:0] == 4'h0 && !cnt_sync && cnt_terminal
		|=> (!cnt_terminal)[*8] ##0 $stable(counter_ctrl_r))
		else $error("terminal count repeated within sixteen-count period");

	////////////////////////////////////////////////////////////////////////
	// sync selection
	logic gain_load_sync;
	logic sync_out_sel;

	assign gain_load_sync = rsr_sync_pick(gain_second_r[`RSR_GAIN_LOAD_LSB +: 2], 1'b0, sync_in_act, cnt_terminal);
	// output sync, code 0 is the one-shot
	assign sync_out_sel = rsr_sync_pick(sync_select_r[`RSR_SYNC_OUT_LSB +: 2], one_shot_pulse_r,
		sync_in_act, cnt_terminal);

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ratio_load_sync <= 1'b0;
			rate_integrator_sync <= 1'b0;
			phase_integrator_sync <= 1'b0;
			fifo_reset_sync <= 1'b0;
			sync_out_n <= 1'b1;
		end else begin
			ratio_load_sync <= rsr_sync_pick(sync_select_r[`RSR_RATIO_LOAD_LSB +: 2], 1'b0,
				sync_in_act, cnt_terminal);
			rate_integrator_sync <= rsr_sync_pick(sync_select_r[`RSR_RATE_INT_LSB +: 2], 1'b0,
				sync_in_act, cnt_terminal);
			phase_integrator_sync <= rsr_sync_pick(sync_select_r[`RSR_PHASE_INT_LSB +: 2], 1'b0,
				sync_in_act, cnt_terminal);
			fifo_reset_sync <= rsr_sync_pick(output_opt_r[`RSR_FIFO_RST_LSB +: 2], 1'b0,
				sync_in_act, cnt_terminal);
			sync_out_n <= !sync_out_sel;
		end
	end

	a_sync_out_pin: assert property (sync_out_n == !$past(sync_out_sel))
		else $error("sync output pin not the inverted selection");
	a_ratio_by_input: assert property (sync_select_r[1:0] == 2'h1 |=> ratio_load_sync == $past(!sync_in_n))
		else $error("ratio load does not follow sync input");
	a_rate_never: assert property (sync_select_r[3:2] == 2'h0 |=> !rate_integrator_sync)
		else $error("rate integrator sync fired in never mode");

	////////////////////////////////////////////////////////////////////////
	// rate lock loop gain paths
	logic [4:0] shift_first_r;
	logic [4:0] shift_second_r;

	// shifts reach the loop only on the selected sync
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			shift_first_r <= 5'h00;
			shift_second_r <= 5'h00;
		end else if (gain_load_sync) begin
			shift_first_r <= gain_first_r[`RSR_GAIN_MSB:`RSR_GAIN_LSB];
			shift_second_r <= gain_second_r[`RSR_GAIN_MSB:`RSR_GAIN_LSB];
		end
	end

	// scale by two to minus shift
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			path_first_err <= '0;
			path_second_err <= '0;
		end else begin
			// signed zero keeps the shift arithmetic for negative errors
			path_first_err <= (shift_first_r == 5'h00) ? $signed(ERR_W'(0)) : (loop_error >>> shift_first_r);
			path_second_err <= (shift_second_r == 5'h00) ? $signed(ERR_W'(0)) : (loop_error >>> shift_second_r);
		end
	end

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			error_raise_ratio <= 1'b0;
		end else begin
			error_raise_ratio <= external_error_input ^ gain_second_r[`RSR_ERR_INV_BIT];
		end
	end

	a_gain_zero_clears: assert property (shift_first_r == 5'h00 |=> path_first_err == '0)
		else $error("zero shift did not clear first path");
	a_gain_scale: assert property (shift_second_r != 5'h00 |=> path_second_err == ($past(loop_error) >>> $past(shift_second_r)))
		else $error("second path not scaled by shift");
	a_gain_hold: assert property (gain_second_r[7:6] == 2'h0 |=> $stable(shift_first_r))
		else $error("shift changed with never-load mode");
	a_error_polarity: assert property (error_raise_ratio == ($past(external_error_input) ^ $past(gain_second_r[5])))
		else $error("external error polarity wrong");

	////////////////////////////////////////////////////////////////////////
	// data paths
	logic change_ahead;
	logic ahead_d1_r;
	logic valid_level;

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			core_data_in <= '0;
		end else if (counter_ctrl_r[`RSR_TEST_PAT_BIT]) begin
			core_data_in <= DATA_W'(cnt_value[`RSR_TEST_PAT_W-1:0]);
		end else begin
			core_data_in <= sample_in;
		end
	end

	a_test_pattern: assert property (counter_ctrl_r[6] |=> core_data_in == DATA_W'($past(cnt_value[11:0])))
		else $error("test pattern not taken from counter");

	// bypass skips the fifo; output clock must equal input clock
	assign change_ahead = output_opt_r[`RSR_BYPASS_BIT] ? core_change_ahead : fifo_change_ahead;
	assign fifo_bypassed = output_opt_r[`RSR_BYPASS_BIT];

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			data_out <= '0;
		end else begin
			data_out <= output_opt_r[`RSR_BYPASS_BIT] ? core_data : fifo_data;
		end
	end

	a_bypass_route: assert property (output_opt_r[2] |=> data_out == $past(core_data))
		else $error("bypass did not route core data");

	// change_ahead marks the cycle three before the data output changes
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ahead_d1_r <= 1'b0;
		end else begin
			ahead_d1_r <= change_ahead;
		end
	end

	assign valid_level = output_opt_r[`RSR_VALID_ADV_BIT] ? change_ahead : ahead_d1_r;

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			output_valid_strobe <= 1'b0;
		end else begin
			output_valid_strobe <= valid_level ^ output_opt_r[`RSR_VALID_INV_BIT];
		end
	end

	sequence s_valid_cfg(logic adv, logic inv);
		output_opt_r[4] == adv && output_opt_r[5] == inv && !wr_en;
	endsequence

	a_valid_normal: assert property ((change_ahead and s_valid_cfg(1'b0, 1'b0)) ##1 s_valid_cfg(1'b0, 1'b0)
		|=> output_valid_strobe)
		else $error("valid strobe not in cycle before data change");
	a_valid_early: assert property ((change_ahead and s_valid_cfg(1'b1, 1'b0)) |=> output_valid_strobe)
		else $error("advanced valid strobe not one clock earlier");
	a_valid_low: assert property (!valid_level && output_opt_r[5] |=> output_valid_strobe)
		else $error("inverted valid strobe not high when idle");

endmodule

/* rtl/rsr_pkg.sv */
// rsr_pkg: types shared by the resampler control register bank.
// assumes: rsr_defs.svh is on the include path.
`include "rsr_defs.svh"

package rsr_pkg;

	typedef enum logic [1:0] {
		RSR_SYNC_NEVER = 2'h0,
		RSR_SYNC_INPUT = 2'h1,
		RSR_SYNC_TERMINAL = 2'h2,
		RSR_SYNC_ALWAYS = 2'h3
	} rsr_sync_mode_type;

	typedef logic [`RSR_CNT_W-1:0] rsr_count_type;

	// common sync-mode decode; code 0 yields zero_src
	function automatic logic rsr_sync_pick(input logic [1:0] mode, input logic zero_src,
		input logic sel1, input logic sel2);
		logic res;
		res = 1'b0;
		case (rsr_sync_mode_type'(mode))
			RSR_SYNC_NEVER: res = zero_src;
			RSR_SYNC_INPUT: res = sel1;
			RSR_SYNC_TERMINAL: res = sel2;
			RSR_SYNC_ALWAYS: res = 1'b1;
			default: res = 1'b0;
		endcase
		return res;
	endfunction

endpackage

/* rtl/rsr_sync_counter.sv */
// rsr_sync_counter: free running sync counter with selectable period.
// assumes: sync_evt is an active-high one-cycle or level sync, already in clk domain.
`timescale 1ns/10ps
`include "rsr_defs.svh"

module rsr_sync_counter #(
	parameter int CNT_W = `RSR_CNT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic [3:0] period_code,
	input wire logic sync_evt,
	// state
	output logic [CNT_W-1:0] count,
	output logic terminal
);
	import rsr_pkg::*;

	initial begin
		if (CNT_W < `RSR_CNT_W) begin
			$error("rsr_sync_counter: CNT_W too small for longest period");
		end
	end

	logic [CNT_W-1:0] last_val;
	logic [CNT_W-1:0] count_r;
	logic terminal_r;

	// period from highest set selector bit; codes between the listed ones round down
	always_comb begin
		last_val = {{(CNT_W-`RSR_CNT_EXP_BASE){1'b0}}, {`RSR_CNT_EXP_BASE{1'b1}}};
		for (int i = 0; i < 4; i++) begin
			if (period_code[i]) begin
				last_val = CNT_W'((64'h1 << (`RSR_CNT_EXP_BASE + `RSR_CNT_EXP_STEP * (i + 1))) - 64'h1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= '0;
		end else if (sync_evt || count_r >= last_val) begin
			count_r <= '0;
		end else begin
			count_r <= count_r + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			terminal_r <= 1'b0;
		end else begin
			terminal_r <= !sync_evt && (count_r == last_val - CNT_W'(1));
		end
	end

	assign count = count_r;
	assign terminal = terminal_r;

endmodule

/* tb/rsr_host_model.sv */
// rsr_host_model: host side of the control bus, byte reads and writes.
// assumes: the block samples the bus on the rising clk edge.
`timescale 1ns/10ps

module rsr_host_model (
	// clock
	input wire logic clk,
	// control bus
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic [3:0] addr,
	output logic [7:0] cdata_in,
	input wire logic [7:0] cdata_out,
	input wire logic cdata_oe
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 4'hF;
		cdata_in = 8'hFF;
	end

	task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		wr_n = 1'b0;
		addr = a;
		cdata_in = d;
		@(posedge clk);
		#1;
		cs_n = 1'b1;
		wr_n = 1'b1;
		// released lines show the inverse, not a stale copy
		addr = ~a;
		cdata_in = ~d;
	endtask

	task automatic read_reg(input logic [3:0] a, output logic [7:0] d, output logic oe);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		rd_n = 1'b0;
		addr = a;
		#1;
		oe = cdata_oe;
		@(posedge clk);
		#1;
		d = cdata_out;
		cs_n = 1'b1;
		rd_n = 1'b1;
		addr = ~a;
	endtask

	// write then read of the same register, back to back
	task automatic write_read(input logic [3:0] a, input logic [7:0] dw, output logic [7:0] dr);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		wr_n = 1'b0;
		addr = a;
		cdata_in = dw;
		@(posedge clk);
		#1;
		wr_n = 1'b1;
		rd_n = 1'b0;
		@(posedge clk);
		#1;
		dr = cdata_out;
		cs_n = 1'b1;
		rd_n = 1'b1;
		addr = ~a;
		cdata_in = ~dw;
	endtask
endmodule

/* tb/rsr_loop_sync_regs_tb.sv */
// rsr_loop_sync_regs_tb: register, sync, counter and output path tests.
// assumes: the host model drives the control bus; bench drives the rest.
`timescale 1ns/10ps

module rsr_loop_sync_regs_tb;
	logic clk, rst_n, sync_in_n, one_shot_bit, external_error_input;
	logic core_change_ahead, fifo_change_ahead;
	logic cs_n, rd_n, wr_n, cdata_oe, sync_out_n, error_raise_ratio;
	logic ratio_load_sync, rate_integrator_sync, phase_integrator_sync, fifo_reset_sync;
	logic output_valid_strobe, fifo_bypassed, oe, e;
	logic [3:0] addr;
	logic [7:0] cdata_in, cdata_out, d;
	logic signed [15:0] loop_error, path_first_err, path_second_err;
	logic [15:0] sample_in, core_data_in, core_data, fifo_data, data_out;
	int err_count, num_checks, p0, p1, n, k;

	rsr_host_model h (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
		.cdata_in(cdata_in), .cdata_out(cdata_out), .cdata_oe(cdata_oe));

	rsr_loop_sync_regs i_rsr_loop_sync_regs (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .addr(addr), .cdata_in(cdata_in), .cdata_out(cdata_out), .cdata_oe(cdata_oe),
		.sync_in_n(sync_in_n), .sync_out_n(sync_out_n), .one_shot_bit(one_shot_bit),
		.loop_error(loop_error), .path_first_err(path_first_err), .path_second_err(path_second_err),
		.external_error_input(external_error_input), .error_raise_ratio(error_raise_ratio),
		.ratio_load_sync(ratio_load_sync), .rate_integrator_sync(rate_integrator_sync),
		.phase_integrator_sync(phase_integrator_sync), .fifo_reset_sync(fifo_reset_sync),
		.sample_in(sample_in), .core_data_in(core_data_in), .core_data(core_data),
		.core_change_ahead(core_change_ahead), .fifo_data(fifo_data),
		.fifo_change_ahead(fifo_change_ahead), .data_out(data_out),
		.output_valid_strobe(output_valid_strobe), .fifo_bypassed(fifo_bypassed));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic wc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// sel 0: ratio sync high, 1: sync pin low
	task automatic count_hi(input int sel, input int c, output int hits);
		hits = 0;
		repeat (c) begin
			@(posedge clk);
			#1;
			if ((sel == 0) ? (ratio_load_sync === 1'b1) : (sync_out_n === 1'b0))
				hits++;
		end
	endtask

	task automatic vpos(input logic core, input logic act, output int p, output int hits);
		p = -1;
		hits = 0;
		if (core)
			core_change_ahead = 1'b1;
		else
			fifo_change_ahead = 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			#1;
			core_change_ahead = 1'b0;
			fifo_change_ahead = 1'b0;
			if (output_valid_strobe === act) begin
				p = i;
				hits++;
			end
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#2000000;
		err_count++;
		final_report;
	end

	initial begin
		err_count = 0;
		num_checks = 0;
		rst_n = 1'b0;
		sync_in_n = 1'b1;
		one_shot_bit = 1'b0;
		external_error_input = 1'b0;
		core_change_ahead = 1'b0;
		fifo_change_ahead = 1'b0;
		loop_error = 16'sh0100;
		sample_in = 16'h1234;
		core_data = 16'hBEEF;
		fifo_data = 16'h1357;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		wc(4);
		////////////////////////////////////////////////////////////////
		for (int a = 6; a < 11; a++) begin
			h.read_reg(4'(a), d, oe);
			chk(d, 16'h00);
			for (int j = 0; j < 2; j++) begin
				h.write_reg(4'(a), j ? 8'h5A : 8'hA5);
				h.read_reg(4'(a), d, oe);
				chk(d, j ? 16'h5A : 16'hA5);
				chk(oe, 1'b1);
			end
		end
		h.read_reg(4'h3, d, oe);
		chk(d, 16'h00);
		chk(oe, 1'b0);
		h.write_read(4'h8, 8'h3C, d);
		chk(d, 16'h3C);
		$display("test registers done");
		////////////////////////////////////////////////////////////////
		h.write_reg(4'h7, 8'hC3);
		h.write_reg(4'h6, 8'h02);
		wc(4);
		chk(path_first_err, 16'h0040);
		chk(path_second_err, 16'h0020);
		h.write_reg(4'h6, 8'h00);
		wc(4);
		chk(path_first_err, 16'h0000);
		h.write_reg(4'h7, 8'h03);
		h.write_reg(4'h6, 8'h04);
		h.write_reg(4'h7, 8'h05);
		wc(4);
		chk(path_second_err, 16'h0020);
		h.write_reg(4'h7, 8'h45);
		sync_in_n = 1'b0;
		wc(1);
		sync_in_n = 1'b1;
		wc(4);
		chk(path_first_err, 16'h0010);
		chk(path_second_err, 16'h0008);
		external_error_input = 1'b1;
		wc(2);
		chk(error_raise_ratio, 1'b1);
		h.write_reg(4'h7, 8'h65);
		wc(2);
		chk(error_raise_ratio, 1'b0);
		loop_error = 16'shFF00;
		wc(2);
		chk(path_first_err, 16'hFFF0);
		$display("test loop gain done");
		////////////////////////////////////////////////////////////////
		h.write_reg(4'h9, 8'h00);
		for (int c = 0; c < 4; c++) begin
			h.write_reg(4'h8, 8'(c * 8'h55));
			h.write_reg(4'hA, 8'(c));
			if (c == 2) begin
				count_hi(0, 32, k);
				chk(16'(k), 16'd2);
				count_hi(1, 32, k);
				chk(16'(k), 16'd2);
			end else begin
				for (int s = 0; s < 2; s++) begin
					sync_in_n = (s == 0);
					wc(3);
					e = (c == 3) || (c == 1 && s == 1);
					chk(ratio_load_sync, e);
					chk(rate_integrator_sync, e);
					chk(phase_integrator_sync, e);
					chk(fifo_reset_sync, e);
					chk(sync_out_n, !e);
				end
			end
		end
		sync_in_n = 1'b1;
		h.write_reg(4'h8, 8'h00);
		one_shot_bit = 1'b1;
		count_hi(1, 8, k);
		chk(16'(k), 16'd1);
		count_hi(1, 8, k);
		chk(16'(k), 16'd0);
		one_shot_bit = 1'b0;
		wc(2);
		one_shot_bit = 1'b1;
		count_hi(1, 8, k);
		chk(16'(k), 16'd1);
		$display("test syncs done");
		////////////////////////////////////////////////////////////////
		for (int q = 0; q < 3; q++) begin
			h.write_reg(4'h9, 8'h40 | ((8'h1 << q) - 8'h1));
			k = 0;
			while (core_data_in[11:0] !== 12'h000 && k < 5000) begin
				wc(1);
				k++;
			end
			n = 0;
			do begin
				wc(1);
				n++;
			end while (core_data_in[11:0] !== 12'h000 && n < 5000);
			chk(16'(n), 16'(1 << (4 + 4 * q)));
			chk(core_data_in[15:12], 4'h0);
		end
		h.write_reg(4'h9, 8'h70);
		wc(3);
		chk(core_data_in, 16'h0000);
		h.write_reg(4'h9, 8'h50);
		sync_in_n = 1'b0;
		wc(3);
		chk(core_data_in, 16'h0000);
		sync_in_n = 1'b1;
		wc(3);
		chk(core_data_in == 16'h0000, 1'b0);
		h.write_reg(4'h9, 8'h60);
		one_shot_bit = 1'b0;
		wc(2);
		one_shot_bit = 1'b1;
		wc(3);
		chk(core_data_in, 16'h0000);
		h.write_reg(4'h9, 8'h00);
		wc(2);
		chk(core_data_in, 16'h1234);
		$display("test counter done");
		////////////////////////////////////////////////////////////////
		h.write_reg(4'hA, 8'h04);
		wc(2);
		chk(data_out, 16'hBEEF);
		chk(fifo_bypassed, 1'b1);
		vpos(1'b1, 1'b1, p0, n);
		chk(16'(p0), 16'd1);
		chk(16'(n), 16'd1);
		h.write_reg(4'hA, 8'h14);
		vpos(1'b1, 1'b1, p1, n);
		chk(16'(p1), 16'(p0 - 1));
		h.write_reg(4'hA, 8'h34);
		wc(2);
		chk(output_valid_strobe, 1'b1);
		vpos(1'b1, 1'b0, p1, n);
		chk(16'(p1), 16'(p0 - 1));
		chk(16'(n), 16'd1);
		h.write_reg(4'hA, 8'h00);
		wc(2);
		chk(data_out, 16'h1357);
		chk(fifo_bypassed, 1'b0);
		vpos(1'b0, 1'b1, p1, n);
		chk(16'(p1), 16'(p0));
		$display("test output path done");
		final_report;
	end
endmodule
